//--- dv/override_source.sv
// Purpose: stand-in peripheral that claims pins and drives overrides
// Assumes: bench picks claimed pins and their levels
// Notes:   raw input is resynchronised here before use
module override_source (
	// control from bench
	input  wire logic       clk,
	input  wire logic [7:0] claim,
	input  wire logic [7:0] level,
	input  wire logic [7:0] raw_digital_input,
	// override outputs
	output logic      [7:0] pu_en,
	output logic      [7:0] pu_v,
	output logic      [7:0] dd_en,
	output logic      [7:0] dd_v,
	output logic      [7:0] pv_en,
	output logic      [7:0] pv_v,
	output logic      [7:0] ig_en,
	output logic      [7:0] ig_v,
	output logic      [7:0] synced
);
	// ****************************************************************
	// per-pin overrides
	// ****************************************************************
	logic [7:0] stage;
	// each claimed pin gets its own value
	assign {pu_en, dd_en, pv_en, ig_en} = {4{claim}};
	assign {pu_v, dd_v, pv_v, ig_v} = {level, ~level, level, level};
	// two-stage resync of the raw input
	always_ff @(posedge clk) begin
		stage <= raw_digital_input;
		synced <= stage;
	end
endmodule : override_source

//--- dv/pin_mux_properties.sv
// Purpose: port-level checks of the pin override selection
// Assumes: overrides, pads and sleep are levels sampled at clk
// Notes:   reset checks stay live while reset is held
module pin_mux_properties
	import pin_mux_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       reset_n,
	// controls and overrides
	input wire logic       sleep_clamp,
	input wire logic [7:0] pullup_override_enable,
	input wire logic [7:0] pullup_override_value,
	input wire logic [7:0] direction_override_enable,
	input wire logic [7:0] direction_override_value,
	input wire logic [7:0] drive_value_override_enable,
	input wire logic [7:0] drive_value_override_value,
	input wire logic [7:0] input_gate_override_enable,
	input wire logic [7:0] input_gate_override_value,
	// pad side
	input wire logic [7:0] raw_digital_input,
	input wire logic [7:0] pad_in,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pullup_on
);
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// steady claim, new direction value
	sequence s_dd_flip;
		$past(reset_n) && $stable(direction_override_enable)
			&& $changed(direction_override_value & direction_override_enable);
	endsequence
	property p_pu_ovr;
		((pullup_on ^ pullup_override_value) & pullup_override_enable) == 8'h00;
	endproperty
	property p_dd_ovr;
		((pad_oe ^ direction_override_value) & direction_override_enable) == 8'h00;
	endproperty
	property p_pv_ovr;
		drive_value_override_enable != 8'h00
			|-> ((pad_out ^ drive_value_override_value) & drive_value_override_enable) == 8'h00;
	endproperty
	property p_ig_ovr;
		((raw_digital_input ^ (pad_in & input_gate_override_value))
			& input_gate_override_enable) == 8'h00;
	endproperty
	property p_ig_sleep;
		((raw_digital_input ^ (pad_in & {8{!sleep_clamp}})) & ~input_gate_override_enable) == 8'h00;
	endproperty
	property p_rst_pu;
		disable iff (1'b0) !reset_n |-> pullup_on == 8'h00;
	endproperty
	property p_rst_oe;
		disable iff (1'b0) !reset_n |-> pad_oe == 8'h00;
	endproperty
	property p_dd_now;
		s_dd_flip |-> $changed(pad_oe & direction_override_enable);
	endproperty
	a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up ignores override");
	a_dd_ovr: assert property (p_dd_ovr) else $error("driver ignores override");
	a_pv_ovr: assert property (p_pv_ovr) else $error("value ignores override");
	a_ig_ovr: assert property (p_ig_ovr) else $error("input gate ignores override");
	a_ig_sleep: assert property (p_ig_sleep) else $error("input gate wrong in sleep");
	a_rst_pu: assert property (p_rst_pu) else $error("pull-up on in reset");
	a_rst_oe: assert property (p_rst_oe) else $error("driver on in reset");
	a_dd_now: assert property (p_dd_now) else $error("override change delayed");
endmodule : pin_mux_properties

bind port_pin_override_mux pin_mux_properties u_props (.*);

//--- dv/port_pin_override_mux_tb.sv
// Purpose: self-checking bench for the pin override mux
// Assumes: APB slave answers when it raises pready
// Notes:   peripheral side played by override_source
module port_pin_override_mux_tb import pin_mux_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// bench
	// ****************************************************************
	logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        sleep_clamp = 1'b0, pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0]  claim = 8'h00, level = 8'h00, pad_in = 8'hC3, raw, pad_out, pad_oe, pullup_on;
	logic [7:0]  pu_en, pu_v, dd_en, dd_v, pv_en, pv_v, ig_en, ig_v;
	int          n_errors = 0, cmp_count = 0;
	// clock
	always #12.5 clk = ~clk;
	port_pin_override_mux u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_clamp(sleep_clamp), .pullup_override_enable(pu_en),
		.pullup_override_value(pu_v), .direction_override_enable(dd_en),
		.direction_override_value(dd_v), .drive_value_override_enable(pv_en),
		.drive_value_override_value(pv_v), .input_gate_override_enable(ig_en),
		.input_gate_override_value(ig_v), .raw_digital_input(raw), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .pullup_on(pullup_on));
	override_source u_peer (.clk(clk), .claim(claim), .level(level), .raw_digital_input(raw),
		.pu_en(pu_en), .pu_v(pu_v), .dd_en(dd_en), .dd_v(dd_v), .pv_en(pv_en), .pv_v(pv_v),
		.ig_en(ig_en), .ig_v(ig_v), .synced());
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk32
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		chk32({24'h0, got}, {24'h0, exp});
	endtask : chk8
	// one transfer; read data and error taken at the pready edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) n_errors++;
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic t_regs();
		apb(1'b0, OFFSET_SPECIAL, 32'h0);
		chk32(rd, {24'h0, SPECIAL_RESET});
		apb(1'b1, OFFSET_SPECIAL, 32'hFFFF_FFA5);
		apb(1'b0, OFFSET_SPECIAL, 32'h0);
		chk32(rd, 32'h0000_00A5);
		apb(1'b0, 12'h040, 32'h0);
		chk32({rd[30:0], err}, 32'h1);
		repeat (3) @(posedge clk);
		apb(1'b0, OFFSET_PIN_INPUT, 32'h0);
		chk32(rd, 32'h0000_00C3);
	endtask : t_regs
	// every dir, out, disable combination with no override
	task automatic t_table();
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, OFFSET_PIN_DIR, c[2] ? 32'hFF : 32'h0);
			apb(1'b1, OFFSET_PIN_OUTPUT, c[1] ? 32'hFF : 32'h0);
			apb(1'b1, OFFSET_SPECIAL, c[0] ? 32'h4 : 32'h0);
			@(negedge clk);
			chk8(pullup_on, (c == 2) ? 8'hFF : 8'h00);
			chk8(pad_oe, {8{c[2]}});
			chk8(pad_out, {8{c[1]}});
		end
	endtask : t_table
	// partial claims over a pull-up base, awake and asleep
	task automatic t_override();
		logic [7:0] c, l;
		apb(1'b1, OFFSET_PIN_DIR, 32'h0);
		apb(1'b1, OFFSET_SPECIAL, 32'h0);
		for (int k = 0; k < 4; k++) begin
			{c, l} = {8'h0F, 8'h36, 8'hA5, 8'hFF} >> (16 * (k / 2));
			{claim, level, sleep_clamp} <= {c, l, k[0]};
			@(negedge clk);
			chk8(pullup_on, (c & l) | ~c);
			chk8(pad_oe, c & ~l);
			chk8(pad_out, (c & l) | ~c);
			chk8(raw, pad_in & ((c & l) | (~c & {8{!k[0]}})));
		end
		sleep_clamp <= 1'b0;
	endtask : t_override
	// reset in mid-run with drivers and pull-ups active
	task automatic t_reset();
		{claim, level} <= {8'h0F, 8'h00};
		@(negedge clk);
		reset_n <= 1'b0;
		#1;
		chk8(pullup_on, 8'h00);
		chk8(pad_oe, 8'h00);
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		apb(1'b0, OFFSET_PIN_OUTPUT, 32'h0);
		chk32(rd, {24'h0, PORT_RESET});
	endtask : t_reset
	task automatic report_and_stop();
		$display("errors=%0d compares=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		t_regs();
		t_table();
		t_override();
		t_reset();
		report_and_stop();
	end
	// watchdog
	initial begin
		#100000;
		n_errors++;
		report_and_stop();
	end
endmodule : port_pin_override_mux_tb

//--- include/pin_mux_pkg.sv
// Purpose: shared constants for the port pin override block
// Assumes: 8-bit ports, APB register slave with 32-bit data
// Notes:   offsets are byte addresses, one aligned word each
package pin_mux_pkg;
	// ********************************************************************
	// widths
	// ********************************************************************
	localparam int PORT_WIDTH = 8;
	localparam int ADDR_WIDTH = 12;
	localparam int DATA_WIDTH = 32;

	// ********************************************************************
	// register map
	// ********************************************************************
	localparam logic [11:0] OFFSET_PIN_OUTPUT = 12'h000;
	localparam logic [11:0] OFFSET_PIN_DIR    = 12'h004;
	localparam logic [11:0] OFFSET_PIN_INPUT  = 12'h008;
	localparam logic [11:0] OFFSET_SPECIAL    = 12'h00C;

	// ********************************************************************
	// special function control fields
	// ********************************************************************
	localparam int          PUD_BIT         = 2;
	localparam logic [7:0]  SPECIAL_RESET   = 8'h00;
	localparam logic [7:0]  PORT_RESET      = 8'h00;
	localparam logic [2:0]  PULLUP_PATTERN  = 3'h2;
endpackage : pin_mux_pkg

//--- logic/pin_override_cell.sv
// Purpose: combinational override selection for one port pin
// Assumes: override signals come from the owning peripheral
// Notes:   no storage, changes take effect at once
module pin_override_cell
	import pin_mux_pkg::*;
(
	// port register bits and shared controls
	input  wire logic pin_direction_bit,
	input  wire logic pin_output_bit,
	input  wire logic global_pullup_disable,
	input  wire logic sleep_clamp,
	input  wire logic in_reset,
	// overrides from the peripheral
	input  wire logic pullup_override_enable,
	input  wire logic pullup_override_value,
	input  wire logic direction_override_enable,
	input  wire logic direction_override_value,
	input  wire logic drive_value_override_enable,
	input  wire logic drive_value_override_value,
	input  wire logic input_gate_override_enable,
	input  wire logic input_gate_override_value,
	// pad side
	input  wire logic pad_in,
	output logic      pad_out,
	output logic      pad_oe,
	output logic      pullup_on,
	output logic      gated_input
);
	logic driver_on;
	logic input_on;

	// selection logic, purely combinational
	always_comb begin
		if (direction_override_enable) begin
			driver_on = direction_override_value;
		end else begin
			driver_on = pin_direction_bit;
		end
		pad_oe = driver_on & ~in_reset;
		if (drive_value_override_enable) begin
			pad_out = drive_value_override_value;
		end else begin
			pad_out = pin_output_bit;
		end
		if (in_reset) begin
			pullup_on = 1'b0;
		end else if (pullup_override_enable) begin
			pullup_on = pullup_override_value;
		end else begin
			pullup_on = ({pin_direction_bit, pin_output_bit, global_pullup_disable}
				== PULLUP_PATTERN);
		end
		if (input_gate_override_enable) begin
			input_on = input_gate_override_value;
		end else begin
			input_on = ~sleep_clamp;
		end
		gated_input = pad_in & input_on;
	end
endmodule : pin_override_cell

//--- logic/port_pin_override_mux.sv
// Purpose: one 8-pin port with peripheral override and APB registers
// Assumes: pad inputs asynchronous to clk, one clock at 40 MHz
// Notes:   raw input to peripherals is unsynchronised
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
import pin_mux_pkg::*;

// Summary of operation
// - pull-up override enable selects override value
// - else pull-up when dir,out,disable = 010
// - direction override enable selects driver value
// - else driver follows direction bit
// - value override drives override value
// - else output bit drives pin
// - input gate override sets input enable
// - else sleep state decides input enable
// - peripheral input taken before synchroniser
// - overrides per pin, controls shared
// - pull-ups off during reset
// - special control eight bits, disable bit two
// - disable bit kills pull-ups on pins without pull-up override
// - direction one means output
// - pins tri-state while reset active
module port_pin_override_mux
	import pin_mux_pkg::*;
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [ADDR_WIDTH-1:0]   paddr,
	input  wire logic [DATA_WIDTH-1:0]   pwdata,
	output logic      [DATA_WIDTH-1:0]   prdata,
	output logic                         pready,
	output logic                         pslverr,
	// shared sleep clamp
	input  wire logic                    sleep_clamp,
	// per-pin overrides from peripherals
	input  wire logic [PORT_WIDTH-1:0]   pullup_override_enable,
	input  wire logic [PORT_WIDTH-1:0]   pullup_override_value,
	input  wire logic [PORT_WIDTH-1:0]   direction_override_enable,
	input  wire logic [PORT_WIDTH-1:0]   direction_override_value,
	input  wire logic [PORT_WIDTH-1:0]   drive_value_override_enable,
	input  wire logic [PORT_WIDTH-1:0]   drive_value_override_value,
	input  wire logic [PORT_WIDTH-1:0]   input_gate_override_enable,
	input  wire logic [PORT_WIDTH-1:0]   input_gate_override_value,
	output logic      [PORT_WIDTH-1:0]   raw_digital_input,
	// pads
	input  wire logic [PORT_WIDTH-1:0]   pad_in,
	output logic      [PORT_WIDTH-1:0]   pad_out,
	output logic      [PORT_WIDTH-1:0]   pad_oe,
	output logic      [PORT_WIDTH-1:0]   pullup_on
);
	// ********************************************************************
	// registers
	// ********************************************************************
	logic [PORT_WIDTH-1:0] pin_output_bit;
	logic [PORT_WIDTH-1:0] pin_direction_bit;
	logic [PORT_WIDTH-1:0] sync_stage;
	logic [PORT_WIDTH-1:0] pin_input_bit;
	logic [7:0]            special_function_control;
	logic [PORT_WIDTH-1:0] next_pin_output_bit;
	logic [PORT_WIDTH-1:0] next_pin_direction_bit;
	logic [PORT_WIDTH-1:0] next_sync_stage;
	logic [PORT_WIDTH-1:0] next_pin_input_bit;
	logic [7:0]            next_special_function_control;
	logic [DATA_WIDTH-1:0] next_prdata;
	logic                  next_pslverr;
	logic                  in_reset;
	logic                  global_pullup_disable;
	logic                  access;
	logic                  mapped;
	logic                  answer_ready;
	logic                  next_answer_ready;
	logic                  first_beat;
	logic                  last_beat;

	assign in_reset              = ~reset_n;
	assign global_pullup_disable = special_function_control[PUD_BIT];

	// address decode
	function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] a);
		is_mapped = (a == OFFSET_PIN_OUTPUT) || (a == OFFSET_PIN_DIR)
			|| (a == OFFSET_PIN_INPUT) || (a == OFFSET_SPECIAL);
	endfunction : is_mapped

	// zero-extend a byte to a bus word
	function automatic logic [DATA_WIDTH-1:0] widen(input logic [7:0] b);
		widen = {{(DATA_WIDTH-8){1'b0}}, b};
	endfunction : widen

	// ********************************************************************
	// apb next-state
	// ********************************************************************
	// one wait state so read data and error come from flops with pready
	assign access     = psel & penable;
	assign mapped     = is_mapped(paddr);
	assign first_beat = access & ~answer_ready;
	assign last_beat  = access & answer_ready;
	assign pready     = answer_ready;

	// register writes, reads and input synchroniser
	always_comb begin
		next_pin_output_bit           = pin_output_bit;
		next_pin_direction_bit        = pin_direction_bit;
		next_special_function_control = special_function_control;
		next_prdata                   = prdata;
		next_pslverr                  = 1'b0;
		next_sync_stage               = pad_in;
		next_pin_input_bit            = sync_stage;
		next_answer_ready             = first_beat;
		// writes land only at the edge that completes the transfer
		if (last_beat && pwrite) begin
			unique case (paddr)
				OFFSET_PIN_OUTPUT: next_pin_output_bit    = pwdata[PORT_WIDTH-1:0];
				OFFSET_PIN_DIR:    next_pin_direction_bit = pwdata[PORT_WIDTH-1:0];
				OFFSET_SPECIAL:    next_special_function_control = pwdata[7:0];
				default:           next_pslverr = 1'b0;
			endcase
		end
		// read data and error are registered during the wait state
		if (first_beat) begin
			next_pslverr = ~mapped;
			next_prdata  = {DATA_WIDTH{1'b0}};
			if (!pwrite) begin
				unique case (paddr)
					OFFSET_PIN_OUTPUT: next_prdata = widen(pin_output_bit);
					OFFSET_PIN_DIR:    next_prdata = widen(pin_direction_bit);
					OFFSET_PIN_INPUT:  next_prdata = widen(pin_input_bit);
					OFFSET_SPECIAL:    next_prdata = widen(special_function_control);
					default:           next_prdata = {DATA_WIDTH{1'b0}};
				endcase
			end
		end
	end

	// register state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pin_output_bit           <= PORT_RESET;
			pin_direction_bit        <= PORT_RESET;
			special_function_control <= SPECIAL_RESET;
			sync_stage               <= PORT_RESET;
			pin_input_bit            <= PORT_RESET;
			prdata                   <= {DATA_WIDTH{1'b0}};
			pslverr                  <= 1'b0;
			answer_ready             <= 1'b0;
		end else begin
			pin_output_bit           <= next_pin_output_bit;
			pin_direction_bit        <= next_pin_direction_bit;
			special_function_control <= next_special_function_control;
			sync_stage               <= next_sync_stage;
			pin_input_bit            <= next_pin_input_bit;
			prdata                   <= next_prdata;
			pslverr                  <= next_pslverr;
			answer_ready             <= next_answer_ready;
		end
	end

	// ********************************************************************
	// per-pin override cells
	// ********************************************************************
	for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pin
		pin_override_cell u_cell (
			.pin_direction_bit           (pin_direction_bit[i]),
			.pin_output_bit              (pin_output_bit[i]),
			.global_pullup_disable       (global_pullup_disable),
			.sleep_clamp                 (sleep_clamp),
			.in_reset                    (in_reset),
			.pullup_override_enable      (pullup_override_enable[i]),
			.pullup_override_value       (pullup_override_value[i]),
			.direction_override_enable   (direction_override_enable[i]),
			.direction_override_value    (direction_override_value[i]),
			.drive_value_override_enable (drive_value_override_enable[i]),
			.drive_value_override_value  (drive_value_override_value[i]),
			.input_gate_override_enable  (input_gate_override_enable[i]),
			.input_gate_override_value   (input_gate_override_value[i]),
			.pad_in                      (pad_in[i]),
			.pad_out                     (pad_out[i]),
			.pad_oe                      (pad_oe[i]),
			.pullup_on                   (pullup_on[i]),
			.gated_input                 (raw_digital_input[i])
		);
	end
endmodule : port_pin_override_mux
